// file: design/otgc_control.v
// OTG analog control register with its link register port
`timescale 1ns/1ns
`include "otgc_consts.vh"
module otgc_control (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       link_clock,
    input  wire [7:0] link_data_in,
    output reg  [7:0] link_data_out,
    output reg        link_data_oe_n,
    input  wire       link_stop,
    output reg        link_dir,
    output reg        link_next,
    input  wire       vbus_comparator_valid,
    input  wire       overcurrent_sense_in,
    input  wire       cable_id_in,
    output reg        bus_power_valid,
    output reg        power_switch_out_low,
    output reg        power_switch_oe_n,
    output reg        bus_supply_charge_on,
    output reg        bus_supply_discharge_on,
    output reg        minus_line_pulldown_on,
    output reg        plus_line_pulldown_on,
    output reg        cable_cable_id_sampler_enable_on,
    output reg        cable_id_sampler_on,
    output reg        cable_id_level
);
    // ==========================================================
    // Port state codes
    localparam [2:0] ST_IDLE     = 3'h0;
    localparam [2:0] ST_WR_DATA  = 3'h1;
    localparam [2:0] ST_WR_STOP  = 3'h2;
    localparam [2:0] ST_RD_TURN  = 3'h3;
    localparam [2:0] ST_RD_DATA  = 3'h4;
    localparam [2:0] ST_RD_BACK  = 3'h5;

    localparam SYNC_W = 13;

    // ==========================================================
    // Input synchronisation
    wire [SYNC_W-1:0] sync_bus;
    wire              lclk_s;
    wire [7:0]        data_s;
    wire              stop_s;
    wire              comp_s;
    wire              fault_s;
    wire              id_s;

    otgc_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({link_clock, link_data_in, link_stop,
                    vbus_comparator_valid, overcurrent_sense_in,
                    cable_id_in}),
        .sync_out (sync_bus)
    );

    assign lclk_s  = sync_bus[12];
    assign data_s  = sync_bus[11:4];
    assign stop_s  = sync_bus[3];
    assign comp_s  = sync_bus[2];
    assign fault_s = sync_bus[1];
    assign id_s    = sync_bus[0];

    // ==========================================================
    // Link clock edge detection
    reg  lclk_prev;
    wire lclk_rise;
    wire lclk_fall;

    always @(posedge clock) begin
        if (sys_rst) begin
            lclk_prev <= 1'b0;
        end else begin
            lclk_prev <= lclk_s;
        end
    end

    assign lclk_rise = lclk_s & ~lclk_prev;
    assign lclk_fall = ~lclk_s & lclk_prev;

    // ==========================================================
    // Mid-period capture of link-driven lines
    reg [7:0] cap_data;
    reg       cap_stop;

    always @(posedge clock) begin
        if (sys_rst) begin
            cap_data <= 8'h00;
            cap_stop <= 1'b0;
        end else if (lclk_fall) begin
            cap_data <= data_s;
            cap_stop <= stop_s;
        end
    end

    // ==========================================================
    // Register port state machine
    reg [2:0] state;
    reg [2:0] next_state;
    reg [5:0] addr;
    reg [5:0] next_addr;
    reg [7:0] wr_byte;
    reg [7:0] next_wr_byte;
    reg       next_dir;
    reg       next_nxt;
    reg [7:0] next_dout;
    reg       next_oe_n;
    reg       commit;
    reg [7:0] ctrl;
    reg [7:0] next_ctrl;
    wire [7:0] ctrl_read;
    wire       alias_hit;

    // Reserved bit stored but read back as zero
    assign ctrl_read = ctrl & `OTGC_READ_MASK; // [RULE13]

    // ==========================================================
    // Alias decode, only the three control aliases answer
    assign alias_hit = (addr == `OTGC_ADDR_WRITE) ||
                       (addr == `OTGC_ADDR_SET) ||
                       (addr == `OTGC_ADDR_CLEAR);

    always @* begin
        next_state   = state;
        next_addr    = addr;
        next_wr_byte = wr_byte;
        next_dir     = link_dir;
        next_nxt     = link_next;
        next_dout    = link_data_out;
        next_oe_n    = link_data_oe_n;
        commit       = 1'b0;
        case (state)
            ST_IDLE: begin
                next_dir  = 1'b0;
                next_oe_n = 1'b1;
                next_nxt  = 1'b0;
                if (cap_data[7:6] == `OTGC_CMD_WRITE) begin
                    next_addr  = cap_data[5:0];
                    next_nxt   = 1'b1;
                    next_state = ST_WR_DATA;
                end else if (cap_data[7:6] == `OTGC_CMD_READ) begin
                    next_addr  = cap_data[5:0];
                    next_nxt   = 1'b1;
                    next_state = ST_RD_TURN;
                end
            end
            ST_WR_DATA: begin
                next_nxt   = 1'b1;
                next_state = ST_WR_STOP;
            end
            ST_WR_STOP: begin
                next_nxt = 1'b0;
                if (cap_stop) begin
                    commit     = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_wr_byte = cap_data;
                end
            end
            ST_RD_TURN: begin
                next_nxt   = 1'b0;
                next_dir   = 1'b1;
                next_state = ST_RD_DATA;
            end
            ST_RD_DATA: begin
                next_oe_n = 1'b0;
                if (alias_hit) begin
                    next_dout = ctrl_read; // [RULE1]
                end else begin
                    next_dout = 8'h00;
                end
                next_state = ST_RD_BACK;
            end
            ST_RD_BACK: begin
                next_oe_n  = 1'b1;
                next_dir   = 1'b0;
                next_dout  = 8'h00;
                next_state = ST_IDLE;
            end
            default: begin
                next_dir   = 1'b0;
                next_nxt   = 1'b0;
                next_oe_n  = 1'b1;
                next_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Write, set and clear aliases
    always @* begin
        next_ctrl = ctrl;
        if (commit) begin
            case (addr)
                `OTGC_ADDR_WRITE: begin
                    next_ctrl = wr_byte; // [RULE1]
                end
                `OTGC_ADDR_SET: begin
                    next_ctrl = ctrl | wr_byte; // [RULE2]
                end
                `OTGC_ADDR_CLEAR: begin
                    next_ctrl = ctrl & ~wr_byte; // [RULE2]
                end
                default: begin
                    next_ctrl = ctrl;
                end
            endcase
        end
    end

    // ==========================================================
    // Port and register flip-flops, advanced on link rising edges
    always @(posedge clock) begin
        if (sys_rst) begin
            state          <= ST_IDLE;
            addr           <= 6'h00;
            wr_byte        <= 8'h00;
            link_dir       <= 1'b0;
            link_next      <= 1'b0;
            link_data_out  <= 8'h00;
            link_data_oe_n <= 1'b1;
            // Bits 2 and 1 set, all others clear
            ctrl           <= `OTGC_RESET_VALUE; // [RULE9] [RULE10] [RULE12]
        end else if (lclk_rise) begin
            state          <= next_state;
            addr           <= next_addr;
            wr_byte        <= next_wr_byte;
            link_dir       <= next_dir;
            link_next      <= next_nxt;
            link_data_out  <= next_dout;
            link_data_oe_n <= next_oe_n;
            ctrl           <= next_ctrl;
        end
    end

    // ==========================================================
    // Power-valid source select
    always @(posedge clock) begin
        if (sys_rst) begin
            bus_power_valid <= 1'b0;
        end else if (ctrl[`OTGC_BIT_EXT_IND_SEL]) begin
            bus_power_valid <= fault_s; // [RULE4]
        end else begin
            bus_power_valid <= comp_s; // [RULE3]
        end
    end

    // ==========================================================
    // Open-drain power switch, pulled low only when bit set
    always @(posedge clock) begin
        if (sys_rst) begin
            power_switch_out_low <= 1'b0;
            power_switch_oe_n    <= 1'b1;
        end else begin
            power_switch_out_low <= 1'b0;
            power_switch_oe_n    <= ~ctrl[`OTGC_BIT_EXT_SUPPLY]; // [RULE5]
        end
    end

    // ==========================================================
    // Session request charge and discharge
    always @(posedge clock) begin
        if (sys_rst) begin
            bus_supply_charge_on    <= 1'b0;
            bus_supply_discharge_on <= 1'b0;
        end else begin
            bus_supply_charge_on    <= ctrl[`OTGC_BIT_CHARGE]; // [RULE6]
            bus_supply_discharge_on <= ctrl[`OTGC_BIT_DISCHARGE]; // [RULE8]
        end
    end

    // ==========================================================
    // Data line pull-downs, connected after reset
    always @(posedge clock) begin
        if (sys_rst) begin
            minus_line_pulldown_on <= 1'b1;
            plus_line_pulldown_on  <= 1'b1;
        end else begin
            minus_line_pulldown_on <= ctrl[`OTGC_BIT_MINUS_PD]; // [RULE9]
            plus_line_pulldown_on  <= ctrl[`OTGC_BIT_PLUS_PD]; // [RULE10]
        end
    end

    // ==========================================================
    // ID pull-up and sampler enables
    always @(posedge clock) begin
        if (sys_rst) begin
            cable_cable_id_sampler_enable_on  <= 1'b0;
            cable_id_sampler_on <= 1'b0;
        end else begin
            cable_cable_id_sampler_enable_on  <= ctrl[`OTGC_BIT_ID_SAMPLER]; // [RULE11]
            cable_id_sampler_on <= ctrl[`OTGC_BIT_ID_SAMPLER]; // [RULE12]
        end
    end

    // ==========================================================
    // ID level, held low while the sampler is powered down
    always @(posedge clock) begin
        if (sys_rst) begin
            cable_id_level <= 1'b0;
        end else if (ctrl[`OTGC_BIT_ID_SAMPLER]) begin
            cable_id_level <= id_s; // [RULE11]
        end else begin
            cable_id_level <= 1'b0; // [RULE12]
        end
    end
endmodule

// file: design/otgc_sync.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module otgc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    // ==========================================================
    // Per-bit flip-flop pairs
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clock) begin
                if (sys_rst) begin
                    stage_one[i] <= 1'b0;
                    stage_two[i] <= 1'b0;
                end else begin
                    stage_one[i] <= async_in[i];
                    stage_two[i] <= stage_one[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage_two;
endmodule

// file: pkg/otgc_consts.vh
// Constants for the OTG analog control register and its link port
// Overview of operation
// [RULE1] Read at 0Ah-0Ch; write, set, clear aliases
// [RULE2] Set ORs ones in, clear removes ones
// [RULE3] Bit 7 picks power-valid source, resets 0
// [RULE4] Select high: overcurrent pin is power-valid
// [RULE5] Bit 6 set drives power switch low
// [RULE6] Bit 4 charges bus supply, resets 0
// [RULE7] Link checks discharge and 2 ms SE0
// [RULE8] Bit 3 discharges; link clears after session-low
// [RULE9] Bit 2 minus-line pull-down, resets 1
// [RULE10] Bit 1 plus-line pull-down, resets 1
// [RULE11] Bit 0 attaches ID pull-up and sampler
// [RULE12] Bit 0 resets 0, sampler powered down
// [RULE13] Bit 5 reserved, writable, reads zero
`ifndef OTGC_CONSTS_VH
`define OTGC_CONSTS_VH

// ==========================================================
// Register addresses
`define OTGC_ADDR_WRITE       6'h0A
`define OTGC_ADDR_SET         6'h0B
`define OTGC_ADDR_CLEAR       6'h0C

// ==========================================================
// Field positions
`define OTGC_BIT_EXT_IND_SEL  7
`define OTGC_BIT_EXT_SUPPLY   6
`define OTGC_BIT_RESERVED     5
`define OTGC_BIT_CHARGE       4
`define OTGC_BIT_DISCHARGE    3
`define OTGC_BIT_MINUS_PD     2
`define OTGC_BIT_PLUS_PD      1
`define OTGC_BIT_ID_SAMPLER   0

// ==========================================================
// Reset value and read mask
`define OTGC_RESET_VALUE      8'h06
`define OTGC_READ_MASK        8'hDF

// ==========================================================
// Link command codes in data bits 7:6
`define OTGC_CMD_WRITE        2'h2
`define OTGC_CMD_READ         2'h3

// ==========================================================
// Link timing
`define OTGC_SYNC_STAGES      2

`endif

// file: tb/otgc_checker.sv
// Assertions on the OTG analog control ports
`timescale 1ns/1ns
module otgc_checker (
    input wire       clock,
    input wire       sys_rst,
    input wire [7:0] link_data_out,
    input wire       link_data_oe_n,
    input wire       link_dir,
    input wire       link_next,
    input wire       vbus_comparator_valid,
    input wire       overcurrent_sense_in,
    input wire       bus_power_valid,
    input wire       power_switch_out_low,
    input wire       power_switch_oe_n,
    input wire       bus_supply_charge_on,
    input wire       bus_supply_discharge_on,
    input wire       minus_line_pulldown_on,
    input wire       plus_line_pulldown_on,
    input wire       cable_cable_id_sampler_enable_on,
    input wire       cable_id_sampler_on,
    input wire       cable_id_level
);
    default clocking cb @(posedge clock); endclocking
    // ==========================================================
    // Properties
    a_reset_state: assert property (sys_rst |=> minus_line_pulldown_on
        && plus_line_pulldown_on && power_switch_oe_n && !link_dir
        && !bus_supply_charge_on && !bus_supply_discharge_on
        && !cable_id_sampler_on && link_data_oe_n)
        else $error("reset state wrong");
    a_switch_low: assert property (power_switch_out_low == 1'b0)
        else $error("power switch value not low");
    a_valid_high: assert property (disable iff (sys_rst)
        (overcurrent_sense_in && vbus_comparator_valid) [*5]
        |=> bus_power_valid) else $error("power valid not high");
    a_valid_low: assert property (disable iff (sys_rst)
        (!overcurrent_sense_in && !vbus_comparator_valid) [*5]
        |=> !bus_power_valid) else $error("power valid not low");
    a_id_pair: assert property (cable_cable_id_sampler_enable_on ==
        cable_id_sampler_on) else $error("pull-up and sampler differ");
    a_id_gated: assert property (disable iff (sys_rst)
        !cable_id_sampler_on [*2] |-> !cable_id_level)
        else $error("id level while sampler off");
    a_next_bound: assert property (disable iff (sys_rst)
        $rose(link_next) |-> ##[1:20] !link_next)
        else $error("next held too long");
    a_data_owner: assert property (disable iff (sys_rst)
        !link_data_oe_n |-> link_dir) else $error("data without dir");
    a_turn_around: assert property (disable iff (sys_rst)
        $rose(link_dir) |-> link_data_oe_n ##[6:10] !link_data_oe_n)
        else $error("no read data after turnaround");
    a_reserved_zero: assert property (disable iff (sys_rst)
        !link_data_oe_n |-> link_data_out[5] == 1'b0)
        else $error("reserved bit read as one");
    c_read: cover property (!link_data_oe_n);
    c_switch: cover property (!power_switch_oe_n);
    c_sampler: cover property (cable_id_sampler_on && cable_id_level);
endmodule

// file: tb/otgc_link_model.sv
// Link controller model driving the register port
`timescale 1ns/1ns
module otgc_link_model (
    output reg       link_clock,
    output reg [7:0] link_data_in,
    output reg       link_stop,
    input wire [7:0] link_data_out,
    input wire       link_data_oe_n
);
    initial begin
        link_clock = 1'b0;
        link_data_in = 8'h00;
        link_stop = 1'b0;
    end
    // One link cycle; clock stands low between frames
    task step(input [7:0] d, input s);
        begin
            link_clock = 1'b1;
            #1;
            link_data_in = d;
            link_stop = s;
            #159;
            link_clock = 1'b0;
            #160;
        end
    endtask
    // Command, byte held two cycles, then stop
    task wr(input [5:0] a, input [7:0] d);
        begin
            step({2'h2, a}, 1'b0);
            step(d, 1'b0);
            step(d, 1'b0);
            step(8'h00, 1'b1);
            step(8'h00, 1'b0);
        end
    endtask
    // Command, idle through turnaround, take data at edge
    task rd(input [5:0] a, output [7:0] q);
        begin
            step({2'h3, a}, 1'b0);
            repeat (3) step(8'h00, 1'b0);
            q = (link_data_oe_n === 1'b0) ? link_data_out : 8'hEE;
            repeat (2) step(8'h00, 1'b0);
        end
    endtask
endmodule

// file: tb/tb_otg_bus_control_register.sv
// Testbench for the OTG analog control register
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    num_errors++; $display("Error %s exp %h got %h", nm, ex, got); end end
module tb_otg_bus_control_register;
    reg clock, sys_rst, vbus_comparator_valid;
    reg overcurrent_sense_in, cable_id_in;
    wire link_clock, link_stop, link_data_oe_n, link_dir, link_next;
    wire [7:0] link_data_in, link_data_out;
    wire bus_power_valid, power_switch_out_low, power_switch_oe_n;
    wire bus_supply_charge_on, bus_supply_discharge_on, cable_id_level;
    wire minus_line_pulldown_on, plus_line_pulldown_on;
    wire cable_cable_id_sampler_enable_on, cable_id_sampler_on;
    int num_errors = 0, n_tests = 0, i;
    reg [7:0] q, cur;
    // Rows: write address, write byte, read address, expected read
    reg [31:0] rows [9] = '{32'h0AFF0ADF, 32'h0C0F0BD0,
        32'h0B050CD5, 32'h0A000A00, 32'h0B480A48,
        32'h0C080B40, 32'h0B100A50,
        32'h0D550D00, 32'h0B000C50};
    otgc_control u_otgc_control (.clock, .sys_rst, .link_clock,
        .link_data_in, .link_data_out, .link_data_oe_n, .link_stop,
        .link_dir, .link_next, .vbus_comparator_valid,
        .overcurrent_sense_in, .cable_id_in, .bus_power_valid,
        .power_switch_out_low, .power_switch_oe_n, .bus_supply_charge_on,
        .bus_supply_discharge_on, .minus_line_pulldown_on,
        .plus_line_pulldown_on, .cable_cable_id_sampler_enable_on,
        .cable_id_sampler_on, .cable_id_level);
    otgc_link_model u_otgc_link_model (.link_clock, .link_data_in,
        .link_stop, .link_data_out, .link_data_oe_n);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task tick(input int n);
        begin
            repeat (n) @(posedge clock);
            #2;
        end
    endtask
    task chk_out(input [7:0] e);
        begin
            `CHK("switch_oe_n", ~e[6], power_switch_oe_n)
            `CHK("charge", e[4], bus_supply_charge_on)
            `CHK("discharge", e[3], bus_supply_discharge_on)
            `CHK("minus_pd", e[2], minus_line_pulldown_on)
            `CHK("plus_pd", e[1], plus_line_pulldown_on)
            `CHK("cable_id_sampler_enable", e[0], cable_cable_id_sampler_enable_on)
            `CHK("id_sampler", e[0], cable_id_sampler_on)
        end
    endtask
    task do_reset;
        begin
            sys_rst = 1'b1;
            tick(5);
            sys_rst = 1'b0;
            tick(4);
            u_otgc_link_model.rd(6'h0A, q);
            `CHK("reset_value", 8'h06, q)
            chk_out(8'h06);
            $display("test reset done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #400000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        sys_rst = 1'b1;
        vbus_comparator_valid = 1'b0;
        overcurrent_sense_in = 1'b0;
        cable_id_in = 1'b0;
        do_reset;
        cur = 8'h06;
        for (i = 0; i < 9; i++) begin
            u_otgc_link_model.wr(rows[i][29:24], rows[i][23:16]);
            u_otgc_link_model.rd(rows[i][13:8], q);
            `CHK("read_back", rows[i][7:0], q)
            if (rows[i][15:8] != 8'h0D)
                cur = rows[i][7:0];
            chk_out(cur);
            $display("test row %0d done", i);
        end
        overcurrent_sense_in = 1'b1;
        vbus_comparator_valid = 1'b1;
        cable_id_in = 1'b1;
        u_otgc_link_model.wr(6'h0A, 8'h81);
        tick(6);
        `CHK("valid_both", 1'b1, bus_power_valid)
        `CHK("id_level", 1'b1, cable_id_level)
        vbus_comparator_valid = 1'b0;
        tick(6);
        `CHK("valid_ext", 1'b1, bus_power_valid)
        u_otgc_link_model.wr(6'h0C, 8'h81);
        tick(6);
        `CHK("valid_int", 1'b0, bus_power_valid)
        `CHK("id_off", 1'b0, cable_id_level)
        overcurrent_sense_in = 1'b0;
        vbus_comparator_valid = 1'b1;
        tick(6);
        `CHK("valid_comp", 1'b1, bus_power_valid)
        $display("test select done");
        u_otgc_link_model.wr(6'h0A, 8'hF9);
        do_reset;
        report_and_stop;
    end
endmodule
bind otgc_control otgc_checker u_otgc_checker (.clock, .sys_rst,
    .link_data_out, .link_data_oe_n, .link_dir, .link_next,
    .vbus_comparator_valid, .overcurrent_sense_in, .bus_power_valid,
    .power_switch_out_low, .power_switch_oe_n, .bus_supply_charge_on,
    .bus_supply_discharge_on, .minus_line_pulldown_on,
    .plus_line_pulldown_on, .cable_cable_id_sampler_enable_on, .cable_id_sampler_on,
    .cable_id_level);
